/* File: shared/ccbs_pkg.sv */
package ccbs_pkg;
  localparam logic [15:0] CFG_LOW_ADDR = 16'h2018;
  localparam logic [15:0] CFG_HIGH_ADDR = 16'h201A;
  localparam logic [15:0] PROG_LOW_ADDR = 16'h0018;
  localparam logic [15:0] PROG_HIGH_ADDR = 16'h001A;
  localparam int PWRDN_EN_BIT = 0;
  localparam int BW_LO_BIT = 1;
  localparam int RC0_BIT = 4;
  localparam int RC1_BIT = 5;
  localparam int RC2_BIT = 1;
  localparam int BW_HI_BIT = 2;
  localparam int WDS_BIT = 3;
  localparam logic [7:0] CFG_ZERO_RESET = 8'h00;
  localparam logic [7:0] CFG_ONE_RESET = 8'h00;
  localparam logic [7:0] IDLE_PWRDN_OPERAND = 8'h02;
  localparam int SYNC_W = 3;
  localparam int SYNC_PROG = 0;
  localparam int SYNC_WIDTH = 1;
  localparam int SYNC_READY = 2;
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  localparam logic [1:0] WMODE_16 = 2'h1;
  localparam logic [1:0] WMODE_8 = 2'h2;
  localparam logic [1:0] WMODE_PIN = 2'h3;

  typedef enum logic [2:0] {
    LD_SETTLE,
    LD_REQ_LOW,
    LD_WAIT_LOW,
    LD_REQ_HIGH,
    LD_WAIT_HIGH,
    LD_RUN
  } ccbs_load_type;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ADDR,
    PH_DATA
  } ccbs_phase_type;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] sync;
  } ccbs_sync_state_type;

  typedef struct packed {
    ccbs_load_type load;
    ccbs_phase_type phase;
    logic [1:0] settle;
    logic prog_sel;
    logic [7:0] cfg_zero;
    logic [7:0] cfg_one;
    logic loaded;
    logic illegal;
    logic nv_rd;
    logic [15:0] nv_addr;
    logic bus16;
    logic busy;
    logic wait_st;
    logic done;
    logic [1:0] wait_cnt;
    logic wdt_always;
    logic powerdown;
  } ccbs_state_type;
endpackage : ccbs_pkg

/* File: hw/ccbs_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ccbs_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [ccbs_pkg::SYNC_W-1:0] async_i,
  output logic [ccbs_pkg::SYNC_W-1:0] sync_o
);
  ccbs_pkg::ccbs_sync_state_type r;
  ccbs_pkg::ccbs_sync_state_type n;

  // The first stage feeds only the second stage.
  always_comb begin
    n = r;
    n.meta = async_i;
    n.sync = r.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign sync_o = r.sync;
endmodule : ccbs_sync
`default_nettype wire

/* File: hw/ccbs_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ccbs_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic prog_entry_i,
  input wire logic width_sel_i,
  input wire logic ready_i,
  input wire logic [7:0] nv_data_i,
  input wire logic nv_valid_i,
  input wire logic cycle_req_i,
  input wire logic idle_pwrdn_req_i,
  input wire logic [7:0] idle_pwrdn_operand_i,
  input wire logic wake_i,
  output logic nv_rd_o,
  output logic [15:0] nv_addr_o,
  output logic [7:0] cfg_zero_o,
  output logic [7:0] cfg_one_o,
  output logic cfg_loaded_o,
  output logic cfg_illegal_o,
  output logic bus16_o,
  output logic cycle_busy_o,
  output logic wait_state_o,
  output logic cycle_done_o,
  output logic wdt_always_o,
  output logic powerdown_o
);
  ccbs_pkg::ccbs_state_type r;
  ccbs_pkg::ccbs_state_type n;
  logic [ccbs_pkg::SYNC_W-1:0] pins_s;
  logic prog_s;
  logic width_s;
  logic ready_s;
  logic [1:0] wmode;
  logic [1:0] wait_lim;
  logic wait_unlim;

  // Pins come from outside the clock domain, so all three pass two flops.
  ccbs_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({ready_i, width_sel_i, prog_entry_i}),
    .sync_o(pins_s)
  );

  assign prog_s = pins_s[ccbs_pkg::SYNC_PROG];
  assign width_s = pins_s[ccbs_pkg::SYNC_WIDTH];
  assign ready_s = pins_s[ccbs_pkg::SYNC_READY];

  function automatic logic [1:0] width_bits(input logic [7:0] z, input logic [7:0] o);
    width_bits = {o[ccbs_pkg::BW_HI_BIT], z[ccbs_pkg::BW_LO_BIT]};
  endfunction : width_bits

  function automatic logic [2:0] ready_bits(input logic [7:0] z, input logic [7:0] o);
    ready_bits = {o[ccbs_pkg::RC2_BIT], z[ccbs_pkg::RC1_BIT], z[ccbs_pkg::RC0_BIT]};
  endfunction : ready_bits

  function automatic logic cfg_bad(input logic [7:0] z, input logic [7:0] o);
    logic [2:0] rb;
    rb = ready_bits(z, o);
    cfg_bad = (width_bits(z, o) == 2'h0) || (!rb[2] && (rb[1:0] != 2'h0));
  endfunction : cfg_bad

  // Illegal width falls back to fixed 8-bit; illegal ready falls back to zero waits.
  always_comb begin
    case (width_bits(r.cfg_zero, r.cfg_one))
      2'h1: wmode = ccbs_pkg::WMODE_16;
      2'h3: wmode = ccbs_pkg::WMODE_PIN;
      default: wmode = ccbs_pkg::WMODE_8;
    endcase
    wait_unlim = 1'b0;
    case (ready_bits(r.cfg_zero, r.cfg_one))
      3'h4: wait_lim = 2'h1;
      3'h5: wait_lim = 2'h2;
      3'h6: wait_lim = 2'h3;
      3'h7: begin
        wait_lim = 2'h0;
        wait_unlim = 1'b1;
      end
      default: wait_lim = 2'h0;
    endcase
  end

  always_comb begin
    n = r;
    n.nv_rd = 1'b0;
    n.done = 1'b0;
    // Load sequence; the configuration registers have no software port at all.
    case (r.load)
      ccbs_pkg::LD_SETTLE: begin
        // The programming-entry strap is caught only once the synchroniser has filled.
        if (r.settle == ccbs_pkg::SETTLE_CYCLES) begin
          n.prog_sel = prog_s;
          n.load = ccbs_pkg::LD_REQ_LOW;
        end else begin
          n.settle = r.settle + 2'h1;
        end
      end
      ccbs_pkg::LD_REQ_LOW: begin
        n.nv_rd = 1'b1;
        n.nv_addr = r.prog_sel ? ccbs_pkg::PROG_LOW_ADDR : ccbs_pkg::CFG_LOW_ADDR;
        n.load = ccbs_pkg::LD_WAIT_LOW;
      end
      ccbs_pkg::LD_WAIT_LOW: begin
        if (nv_valid_i) begin
          n.cfg_zero = nv_data_i;
          n.load = ccbs_pkg::LD_REQ_HIGH;
        end
      end
      ccbs_pkg::LD_REQ_HIGH: begin
        n.nv_rd = 1'b1;
        n.nv_addr = r.prog_sel ? ccbs_pkg::PROG_HIGH_ADDR : ccbs_pkg::CFG_HIGH_ADDR;
        n.load = ccbs_pkg::LD_WAIT_HIGH;
      end
      ccbs_pkg::LD_WAIT_HIGH: begin
        if (nv_valid_i) begin
          n.cfg_one = nv_data_i;
          n.loaded = 1'b1;
          n.illegal = cfg_bad(r.cfg_zero, nv_data_i);
          n.wdt_always = !nv_data_i[ccbs_pkg::WDS_BIT];
          n.load = ccbs_pkg::LD_RUN;
        end
      end
      ccbs_pkg::LD_RUN: begin
        n.load = ccbs_pkg::LD_RUN;
      end
      default: n.load = ccbs_pkg::LD_SETTLE;
    endcase
    // Bus cycle: address phase, then data phase stretched by wait states.
    case (r.phase)
      ccbs_pkg::PH_IDLE: begin
        if (cycle_req_i) begin
          n.busy = 1'b1;
          n.wait_cnt = 2'h0;
          n.phase = ccbs_pkg::PH_ADDR;
        end
      end
      ccbs_pkg::PH_ADDR: begin
        // The width pin is looked at only now, once the address is out.
        if (!r.loaded) begin
          n.bus16 = 1'b0;
        end else if (wmode == ccbs_pkg::WMODE_PIN) begin
          n.bus16 = width_s;
        end else begin
          n.bus16 = (wmode == ccbs_pkg::WMODE_16);
        end
        n.phase = ccbs_pkg::PH_DATA;
      end
      ccbs_pkg::PH_DATA: begin
        // Unlimited mode relies on outside logic raising ready in time.
        if (ready_s || (!wait_unlim && r.wait_cnt == wait_lim)) begin
          n.done = 1'b1;
          n.busy = 1'b0;
          n.wait_st = 1'b0;
          n.phase = ccbs_pkg::PH_IDLE;
        end else begin
          n.wait_st = 1'b1;
          n.wait_cnt = r.wait_cnt + 2'h1;
        end
      end
      default: n.phase = ccbs_pkg::PH_IDLE;
    endcase
    // Powerdown request; the set wins over a wake in the same cycle.
    if (wake_i) begin
      n.powerdown = 1'b0;
    end
    if (idle_pwrdn_req_i && idle_pwrdn_operand_i == ccbs_pkg::IDLE_PWRDN_OPERAND && r.loaded
        && r.cfg_zero[ccbs_pkg::PWRDN_EN_BIT]) begin
      n.powerdown = 1'b1;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
      r.load <= ccbs_pkg::LD_SETTLE;
      r.phase <= ccbs_pkg::PH_IDLE;
      r.cfg_zero <= ccbs_pkg::CFG_ZERO_RESET;
      r.cfg_one <= ccbs_pkg::CFG_ONE_RESET;
    end else begin
      r <= n;
    end
  end

  assign nv_rd_o = r.nv_rd;
  assign nv_addr_o = r.nv_addr;
  assign cfg_zero_o = r.cfg_zero;
  assign cfg_one_o = r.cfg_one;
  assign cfg_loaded_o = r.loaded;
  assign cfg_illegal_o = r.illegal;
  assign bus16_o = r.bus16;
  assign cycle_busy_o = r.busy;
  assign wait_state_o = r.wait_st;
  assign cycle_done_o = r.done;
  assign wdt_always_o = r.wdt_always;
  assign powerdown_o = r.powerdown;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  a_width_boot_narrow: assert property (
    !cfg_loaded_o |-> !bus16_o)
    else $error("bus left 8-bit mode before configuration load");

  a_width_mode_pick: assert property (
    r.phase == ccbs_pkg::PH_ADDR && cfg_loaded_o && wmode != ccbs_pkg::WMODE_PIN
    |=> bus16_o == (width_bits(cfg_zero_o, cfg_one_o) == 2'h1))
    else $error("fixed bus width does not follow width bits");

  a_width_pin_sample: assert property (
    r.phase == ccbs_pkg::PH_ADDR && cfg_loaded_o && wmode == ccbs_pkg::WMODE_PIN
    |=> bus16_o == $past(width_s))
    else $error("pin mode width does not follow sampled pin");

  a_fetch_low_addr: assert property (
    nv_rd_o && !cfg_loaded_o && r.load == ccbs_pkg::LD_WAIT_LOW
    |-> nv_addr_o == (r.prog_sel ? ccbs_pkg::PROG_LOW_ADDR : ccbs_pkg::CFG_LOW_ADDR))
    else $error("low configuration byte fetched from wrong address");

  a_load_high_byte: assert property (
    r.load == ccbs_pkg::LD_WAIT_HIGH && nv_valid_i
    |=> cfg_loaded_o && cfg_one_o == $past(nv_data_i) && !nv_rd_o)
    else $error("high configuration byte not loaded");

  a_cfg_frozen: assert property (
    cfg_loaded_o |=> $stable(cfg_zero_o) && $stable(cfg_one_o) && cfg_loaded_o)
    else $error("configuration changed after load");

  a_wdt_select: assert property (
    cfg_loaded_o |-> wdt_always_o == !cfg_one_o[ccbs_pkg::WDS_BIT])
    else $error("watchdog start select mismatch");

  a_pwrdn_blocked: assert property (
    idle_pwrdn_req_i && !cfg_zero_o[ccbs_pkg::PWRDN_EN_BIT] && !powerdown_o |=> !powerdown_o)
    else $error("powerdown entered while disabled");

  a_pwrdn_enter: assert property (
    idle_pwrdn_req_i && idle_pwrdn_operand_i == ccbs_pkg::IDLE_PWRDN_OPERAND && cfg_loaded_o
    && cfg_zero_o[ccbs_pkg::PWRDN_EN_BIT] |=> powerdown_o)
    else $error("enabled powerdown request ignored");

  a_wait_hold: assert property (
    r.phase == ccbs_pkg::PH_DATA && !ready_s && (wait_unlim || r.wait_cnt < wait_lim)
    |=> wait_state_o && !cycle_done_o)
    else $error("wait state not inserted while ready low");

  a_wait_limit: assert property (
    r.phase == ccbs_pkg::PH_DATA && !wait_unlim && r.wait_cnt == wait_lim
    |=> cycle_done_o && !wait_state_o)
    else $error("cycle ran past programmed wait count");

  a_ready_ends: assert property (
    r.phase == ccbs_pkg::PH_DATA && ready_s |=> cycle_done_o ##1 !cycle_done_o)
    else $error("ready high did not end the cycle");

  a_illegal_flag: assert property (
    cfg_loaded_o |-> cfg_illegal_o == cfg_bad(cfg_zero_o, cfg_one_o))
    else $error("illegal configuration flag wrong");

  c_load_done: cover property (r.load == ccbs_pkg::LD_WAIT_HIGH && nv_valid_i);
  c_three_waits: cover property (wait_state_o [*3] ##1 cycle_done_o);
  c_pin_wide: cover property (wmode == ccbs_pkg::WMODE_PIN && bus16_o);
  c_powerdown: cover property ($rose(powerdown_o));
endmodule : ccbs_top
`default_nettype wire

/* File: tb/ccbs_nv_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ccbs_nv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [15:0] addr_i,
  input wire logic [31:0] mem_i,
  input wire logic slow_i,
  input wire logic busy_i,
  input wire logic [3:0] rdy_after_i,
  output logic valid_o,
  output logic [7:0] data_o,
  output logic ready_o
);
  logic pend_r;
  logic [1:0] lat_r;
  logic [3:0] cnt_r;
  logic [7:0] sel;
  // Only the four configuration locations hold data; other addresses read a filler.
  always_comb begin
    case (addr_i)
      ccbs_pkg::CFG_LOW_ADDR: sel = mem_i[7:0];
      ccbs_pkg::CFG_HIGH_ADDR: sel = mem_i[15:8];
      ccbs_pkg::PROG_LOW_ADDR: sel = mem_i[23:16];
      ccbs_pkg::PROG_HIGH_ADDR: sel = mem_i[31:24];
      default: sel = 8'hA5;
    endcase
  end
  // Ready stays low for a bounded count of busy cycles; 15 means never.
  assign ready_o = busy_i && (cnt_r >= rdy_after_i);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pend_r <= 1'b0;
      lat_r <= 2'h0;
      cnt_r <= 4'h0;
      valid_o <= 1'b0;
      data_o <= 8'h00;
    end else begin
      cnt_r <= !busy_i ? 4'h0 : (cnt_r < 4'hE) ? cnt_r + 4'h1 : cnt_r;
      valid_o <= 1'b0;
      // Released data toggles so that a stale byte is never mistaken for an answer.
      data_o <= ~data_o;
      if (rd_i) begin
        pend_r <= 1'b1;
        lat_r <= slow_i ? 2'h3 : 2'h0;
      end else if (pend_r && lat_r == 2'h0) begin
        pend_r <= 1'b0;
        valid_o <= 1'b1;
        data_o <= sel;
      end else if (pend_r) begin
        lat_r <= lat_r - 2'h1;
      end
    end
  end
endmodule : ccbs_nv_model
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic prog_entry_i = 1'b0;
  logic width_sel_i = 1'b0;
  logic cycle_req_i = 1'b0;
  logic idle_pwrdn_req_i = 1'b0;
  logic [7:0] idle_pwrdn_operand_i = 8'h00;
  logic wake_i = 1'b0;
  logic slow = 1'b0;
  logic [3:0] rdy_after = 4'hF;
  logic [31:0] mem = 32'h0;
  logic ready_i, nv_valid_i, nv_rd_o, cfg_loaded_o, cfg_illegal_o, bus16_o;
  logic cycle_busy_o, wait_state_o, cycle_done_o, wdt_always_o, powerdown_o;
  logic [7:0] nv_data_i, cfg_zero_o, cfg_one_o;
  logic [15:0] nv_addr_o;
  int n_errors = 0;
  int n_compared = 0;
  int len, nw;
  always #5 clk_i = ~clk_i;
  ccbs_top dut (.clk_i, .rst_i, .prog_entry_i, .width_sel_i, .ready_i, .nv_data_i,
    .nv_valid_i, .cycle_req_i, .idle_pwrdn_req_i, .idle_pwrdn_operand_i, .wake_i, .nv_rd_o,
    .nv_addr_o, .cfg_zero_o, .cfg_one_o, .cfg_loaded_o, .cfg_illegal_o, .bus16_o,
    .cycle_busy_o, .wait_state_o, .cycle_done_o, .wdt_always_o, .powerdown_o);
  ccbs_nv_model nvm (.clk_i, .rst_i, .rd_i(nv_rd_o), .addr_i(nv_addr_o), .mem_i(mem),
    .slow_i(slow), .busy_i(cycle_busy_o), .rdy_after_i(rdy_after), .valid_o(nv_valid_i),
    .data_o(nv_data_i), .ready_o(ready_i));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic test_done();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done
  task automatic cyc();
    for (int i = 0; i < 40 && cycle_busy_o; i++) @(posedge clk_i);
    @(posedge clk_i);
    cycle_req_i <= 1'b1;
    @(posedge clk_i);
    cycle_req_i <= 1'b0;
    len = 0;
    nw = 0;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #1;
      len++;
      nw += int'(wait_state_o);
      if (cycle_done_o === 1'b1) break;
    end
  endtask : cyc
  // The unused byte pair holds the inverse, so fetching the wrong pair shows up.
  task automatic boot(input logic [7:0] lo, input logic [7:0] hi, input logic pg,
                      input logic early);
    @(posedge clk_i);
    mem <= pg ? {hi, lo, ~hi, ~lo} : {~hi, ~lo, hi, lo};
    prog_entry_i <= pg;
    slow <= early;
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk("reset", {cfg_loaded_o, nv_rd_o, cycle_busy_o, powerdown_o, cfg_zero_o}, 16'h0);
    @(posedge clk_i);
    rst_i <= 1'b0;
    if (early) begin
      cyc();
      chk("early_bus16", {cfg_loaded_o, bus16_o}, 16'h0);
    end
    for (int i = 0; i < 200 && cfg_loaded_o !== 1'b1; i++) @(posedge clk_i);
    #1;
    chk("cfg_zero", cfg_zero_o, lo);
    chk("cfg_one", cfg_one_o, hi);
    chk("wdt_always", wdt_always_o, !hi[3]);
    chk("cfg_loaded", cfg_loaded_o, 1'b1);
    chk("nv_addr", nv_addr_o, pg ? ccbs_pkg::PROG_HIGH_ADDR : ccbs_pkg::CFG_HIGH_ADDR);
  endtask : boot
  // Table rows: high width bit, low width bit, pin level, expected 16-bit, illegal.
  task automatic t_width();
    logic [4:0] tb_rows [5] = '{5'b00001, 5'b01010, 5'b10100, 5'b11000, 5'b11110};
    foreach (tb_rows[i]) begin
      @(posedge clk_i);
      width_sel_i <= tb_rows[i][2];
      boot({6'h00, tb_rows[i][3], 1'b0}, {5'h1A, tb_rows[i][4], 2'b00}, 1'b0, i == 1);
      cyc();
      chk("bus16", bus16_o, tb_rows[i][1]);
      chk("illegal_w", cfg_illegal_o, tb_rows[i][0]);
    end
    $display("test width done");
  endtask : t_width
  task automatic t_waits();
    logic [2:0] n;
    rdy_after <= 4'hF;
    for (int c = 0; c < 7; c++) begin
      n = c[2] ? {1'b0, c[1:0]} + 3'h1 : 3'h0;
      boot({2'b00, c[1:0], 4'h0}, {6'h35, c[2], 1'b0}, 1'b0, 1'b0);
      cyc();
      chk("cycle_len", len[15:0], 16'(n) + 16'h2);
      chk("wait_cnt", nw[15:0], 16'(n));
      chk("illegal_r", cfg_illegal_o, !c[2] && c != 0);
    end
    rdy_after <= 4'h6;
    boot(8'h30, 8'hD6, 1'b0, 1'b0);
    cyc();
    chk("unlimited", (nw > 3) && (len < 30), 1'b1);
    rdy_after <= 4'h1;
    boot(8'h20, 8'hD6, 1'b0, 1'b0);
    cyc();
    chk("early_ready", nw < 3, 1'b1);
    rdy_after <= 4'hF;
    $display("test waits done");
  endtask : t_waits
  task automatic pwrdn_try(input logic [7:0] op, input logic exp);
    @(posedge clk_i);
    idle_pwrdn_req_i <= 1'b1;
    idle_pwrdn_operand_i <= op;
    @(posedge clk_i);
    idle_pwrdn_req_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("powerdown", powerdown_o, exp);
  endtask : pwrdn_try
  task automatic t_power();
    boot(8'h01, 8'hD4, 1'b0, 1'b0);
    pwrdn_try(8'h01, 1'b0);
    pwrdn_try(ccbs_pkg::IDLE_PWRDN_OPERAND, 1'b1);
    @(posedge clk_i);
    wake_i <= 1'b1;
    @(posedge clk_i);
    wake_i <= 1'b0;
    @(posedge clk_i);
    #1;
    chk("wake", powerdown_o, 1'b0);
    boot(8'h00, 8'hDC, 1'b0, 1'b0);
    pwrdn_try(ccbs_pkg::IDLE_PWRDN_OPERAND, 1'b0);
    boot(8'h00, 8'hD4, 1'b1, 1'b0);
    $display("test power and prog done");
  endtask : t_power
  // Every boot and cycle is short, so this span is far beyond a healthy run.
  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    test_done();
  end
  initial begin
    t_width();
    t_waits();
    t_power();
    test_done();
  end
endmodule : tb_top
`default_nettype wire
